// ---- inc/pmw_clk_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface pmw_clk_if;
  pmw_pkg::pmw_mode_t mode;
  logic               sys_clk_en;

  modport ctrl (output mode, input sys_clk_en);
  modport gate (input mode, output sys_clk_en);
endinterface
`default_nettype wire

// ---- inc/pmw_pkg.sv ----
`default_nettype none
package pmw_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int unsigned ADDR_W            = 8;
  localparam int unsigned DATA_W            = 32;
  localparam logic [7:0]  OFF_POWER_CONTROL = 8'h00;
  localparam logic [7:0]  OFF_WAKE_ENABLE   = 8'h04;
  localparam logic [7:0]  OFF_WAKE_PENDING  = 8'h08;
  localparam logic [7:0]  OFF_CONFIG        = 8'h0C;
  localparam logic [7:0]  OFF_IRQ_STATUS    = 8'h10;
  localparam logic [7:0]  OFF_IRQ_MASK      = 8'h14;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int unsigned PC_SLOW_BIT       = 0;
  localparam int unsigned PC_STOP_BIT       = 1;
  localparam int unsigned PC_SWB_BIT        = 2;
  localparam int unsigned CFG_OSC_OFF_BIT   = 0;
  localparam int unsigned CFG_OSC_RUN_BIT   = 1;

  // Wake sources, one bit each in enable and pending.
  localparam int unsigned WAKE_N            = 7;
  localparam int unsigned WK_REMOTE         = 0;
  localparam int unsigned WK_MAGIC          = 1;
  localparam int unsigned WK_FRAME          = 2;
  localparam int unsigned WK_PHY            = 3;
  localparam int unsigned WK_SEC_PHY        = 4;
  localparam int unsigned WK_SER_C          = 5;
  localparam int unsigned WK_RING           = 6;
  localparam logic [6:0]  WAKE_RISE_MASK    = 7'h1F;
  localparam logic [6:0]  WAKE_OSC_OFF_MASK = 7'h61;

  localparam int unsigned IRQ_N             = 3;
  localparam int unsigned IRQ_WAKE          = 0;
  localparam int unsigned IRQ_SWITCHBACK    = 1;
  localparam int unsigned IRQ_STOP_EXIT     = 2;

  // Configuration byte taken from the EEPROM at this offset.
  localparam logic [7:0]  CFG_EEPROM_OFFSET = 8'h01;
  localparam int unsigned CFG_FLAG_OSC_BIT  = 1;

  // ------------------------------------------------------------------
  // Clocking and vectors
  // ------------------------------------------------------------------
  localparam int unsigned SLOW_DIV          = 100;
  localparam int unsigned DIV_W             = 7;
  localparam logic [6:0]  SLOW_LAST         = 7'(SLOW_DIV - 1);
  localparam logic [23:0] RESET_VECTOR      = 24'h00_0000;
  localparam logic [23:0] WAKE_VECTOR       = 24'h00_005B;
  localparam logic [3:0]  WAKE_PRIO         = 4'hC;

  typedef enum logic [1:0] {
    PMW_FULL,
    PMW_SLOW,
    PMW_STOP
  } pmw_mode_t;

endpackage
`default_nettype wire

// ---- rtl/pmw_clk_gate.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmw_clk_gate (
  input  wire logic core_clk, // Main clock.
  input  wire logic rst,      // Asynchronous reset, active high.
  pmw_clk_if.gate   cif       // Mode in, system clock enable out.
);
  typedef struct packed {
    logic [pmw_pkg::DIV_W-1:0] cnt;
    logic                      en;
  } pmw_gate_st_t;

  pmw_gate_st_t st;
  pmw_gate_st_t next_st;

  // The enable only ever changes at a clock edge from a flop, so the gated
  // clock sees whole pulses or none at every mode change.
  always_comb begin
    next_st = st;
    case (cif.mode)
      pmw_pkg::PMW_FULL: begin
        next_st.cnt = '0;
        next_st.en  = 1'b1;
      end
      pmw_pkg::PMW_SLOW: begin
        if (st.cnt == pmw_pkg::SLOW_LAST) begin
          next_st.cnt = '0;
          next_st.en  = 1'b1;
        end else begin
          next_st.cnt = st.cnt + 7'h1;
          next_st.en  = 1'b0;
        end
      end
      pmw_pkg::PMW_STOP: begin
        next_st.cnt = '0;
        next_st.en  = 1'b0;
      end
      default: begin
        next_st.cnt = '0;
        next_st.en  = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '{cnt: '0, en: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign cif.sys_clk_en = st.en;

  AST_SLOW_GAP: assert property (@(posedge core_clk) disable iff (rst)
    (cif.mode == pmw_pkg::PMW_SLOW && $past(cif.mode) == pmw_pkg::PMW_SLOW
     && $past(st.cnt) != pmw_pkg::SLOW_LAST) |-> !st.en)
    else $error("Slow clock enable came early.");

  AST_FULL_RUNS: assert property (@(posedge core_clk) disable iff (rst)
    (cif.mode == pmw_pkg::PMW_FULL) [*2] |-> st.en)
    else $error("Full speed clock enable missing.");
endmodule
`default_nettype wire

// ---- rtl/pmw_top.sv ----
// Function
// - In slow mode the system clock enable fires once every hundred cycles.
// - Software sets or clears slow mode with power control bit 0.
// - With switchback enabled, a qualifying event returns slow mode to full speed.
// - External irqs, serial start bits, transmit loads, watchdog reset trigger switchback.
// - Enabled wake sources also leave slow mode through the wake interrupt.
// - Stop mode gates the system clock off completely.
// - Software enters stop mode by setting power control bit 1.
// - In stop mode processing, timers and serial traffic are halted.
// - A configuration flag chooses whether oscillator and PLL stop in stop mode.
// - The CPU stalls on the stop write; software follows it with a no-op.
// - Oscillator off: only remote wake, third serial receive, ring indicator, reset wake.
// - Oscillator running: magic packet, wakeup frame, PHY link-up also wake.
// - Hardware reset ends stop mode and restarts the CPU at address zero.
// - Stop wake comes through the wake interrupt and re-enables the clock.
// - Clocked sources cannot wake the device from stop mode.
// - After stop wake the CPU fetches the waking vector, then resumes after stop.
// - The wake interrupt uses vector 0x5B at natural priority 12.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pmw_top (
  input  wire logic        core_clk,           // Main clock, 100 MHz.
  input  wire logic        rst,                // Asynchronous reset, active high.
  input  wire logic [7:0]  paddr,              // APB address.
  input  wire logic        psel,               // APB select.
  input  wire logic        penable,            // APB enable.
  input  wire logic        pwrite,             // APB direction.
  input  wire logic [31:0] pwdata,             // APB write data.
  output logic             pready,             // APB ready.
  output logic [31:0]      prdata,             // APB read data.
  output logic             pslverr,            // APB error on unmapped address.
  output logic             irq,                // Level interrupt to the CPU.
  input  wire logic        ext_irq_a,          // External interrupt request A.
  input  wire logic        ext_irq_b,          // External interrupt request B.
  input  wire logic        serial_a_rx_pin,    // Serial port A receive pin.
  input  wire logic        serial_b_rx_pin,    // Serial port B receive pin.
  input  wire logic        tx_load_a,          // Serial A transmit buffer loaded.
  input  wire logic        tx_load_b,          // Serial B transmit buffer loaded.
  input  wire logic        wdt_reset,          // Watchdog reset pulse.
  input  wire logic        remote_wake_pin,    // Remote wake pin.
  input  wire logic        magic_packet,       // Magic packet seen.
  input  wire logic        wakeup_frame,       // Wakeup frame seen.
  input  wire logic        phy_link_up,        // Embedded PHY link up.
  input  wire logic        sec_phy_link_up,    // Secondary PHY link up.
  input  wire logic        serial_c_rx_pin,    // Third serial port receive pin.
  input  wire logic        ring_indicator_pin, // Third serial port ring indicator.
  input  wire logic        cfg_load,           // Configuration byte valid pulse.
  input  wire logic [7:0]  cfg_flags,          // Configuration flag byte.
  output logic             sys_clk_en,         // Gate enable for system logic clock.
  output logic             osc_pll_en,         // Oscillator and PLL run enable.
  output logic             cpu_stall,          // Holds the CPU pipeline.
  output logic             timers_halt,        // Stops all timers.
  output logic             serial_halt,        // Stops serial traffic.
  output logic             wake_interrupt,     // Wake interrupt request level.
  output logic [3:0]       wake_irq_prio,      // Natural priority of the wake interrupt.
  output logic [23:0]      cpu_vector_addr,    // Address the CPU fetches next.
  output logic             cpu_vector_load     // CPU loads cpu_vector_addr.
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                          slow;
    logic                          stop;
    logic                          switchback_enable;
    logic                          osc_off;
    logic [pmw_pkg::WAKE_N-1:0]    wake_en;
    logic [pmw_pkg::WAKE_N-1:0]    pending;
    logic [pmw_pkg::IRQ_N-1:0]     irq_st;
    logic [pmw_pkg::IRQ_N-1:0]     irq_mask;
    logic                          ack;
    logic [pmw_pkg::DATA_W-1:0]    rdata;
    logic [23:0]                   vec_addr;
    logic                          vec_load;
  } pmw_top_st_t;

  pmw_top_st_t                  st;
  pmw_top_st_t                  next_st;
  logic [pmw_pkg::WAKE_N-1:0]   wake_edge;
  logic [pmw_pkg::WAKE_N-1:0]   wake_raw;
  logic [pmw_pkg::WAKE_N-1:0]   wake_evt;
  logic [pmw_pkg::WAKE_N-1:0]   wake_set;
  logic [1:0]                   ser_pins;
  logic [1:0]                   ser_fall;
  logic                         sb_evt;
  logic                         sb_go;
  logic                         wake_sb;
  logic                         stop_exit;
  logic                         acc_en;
  logic                         wr_en;
  logic                         mapped;
  logic                         stop_wr;

  pmw_clk_if cif ();

  // ------------------------------------------------------------------
  // Edge detectors
  // ------------------------------------------------------------------
  assign wake_raw = {ring_indicator_pin, serial_c_rx_pin, sec_phy_link_up, phy_link_up,
                     wakeup_frame, magic_packet, remote_wake_pin};
  assign ser_pins = {serial_b_rx_pin, serial_a_rx_pin};

  for (genvar i = 0; i < pmw_pkg::WAKE_N; i++) begin : g_wake
    pmw_wake_edge #(
      .RISE (pmw_pkg::WAKE_RISE_MASK[i])
    ) u_edge (
      .core_clk (core_clk),
      .rst      (rst),
      .level    (wake_raw[i]),
      .pulse    (wake_edge[i])
    );
  end

  // Start bits on the two clocked serial ports are falling edges.
  for (genvar j = 0; j < 2; j++) begin : g_ser
    pmw_wake_edge #(
      .RISE (1'b0)
    ) u_edge (
      .core_clk (core_clk),
      .rst      (rst),
      .level    (ser_pins[j]),
      .pulse    (ser_fall[j])
    );
  end

  pmw_clk_gate u_gate (
    .core_clk (core_clk),
    .rst      (rst),
    .cif      (cif)
  );

  // ------------------------------------------------------------------
  // Event qualification
  // ------------------------------------------------------------------
  assign wake_evt = wake_edge & st.wake_en;
  // With the oscillator down only the pin-driven sources can still be seen.
  assign wake_set = (st.stop && st.osc_off) ? (wake_evt & pmw_pkg::WAKE_OSC_OFF_MASK)
                                            : wake_evt;
  assign sb_evt   = ext_irq_a | ext_irq_b | (|ser_fall) | tx_load_a | tx_load_b
                  | wdt_reset;
  // Clocked sources are never looked at while stopped.
  assign sb_go     = st.slow && !st.stop && st.switchback_enable && sb_evt;
  assign wake_sb   = st.slow && !st.stop && (|wake_set);
  assign stop_exit = st.stop && (|wake_set);

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  assign acc_en  = psel && penable && !st.ack;
  assign wr_en   = psel && penable && st.ack && pwrite;
  assign stop_wr = wr_en && (paddr == pmw_pkg::OFF_POWER_CONTROL)
                   && pwdata[pmw_pkg::PC_STOP_BIT];
  assign mapped  = (paddr == pmw_pkg::OFF_POWER_CONTROL) || (paddr == pmw_pkg::OFF_WAKE_ENABLE)
                || (paddr == pmw_pkg::OFF_WAKE_PENDING) || (paddr == pmw_pkg::OFF_CONFIG)
                || (paddr == pmw_pkg::OFF_IRQ_STATUS) || (paddr == pmw_pkg::OFF_IRQ_MASK);

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    logic [pmw_pkg::DATA_W-1:0] rd_val;
    rd_val   = '0;
    next_st  = st;
    next_st.vec_load = 1'b0;
    next_st.ack      = acc_en;

    case (paddr)
      pmw_pkg::OFF_POWER_CONTROL: begin
        rd_val[pmw_pkg::PC_SLOW_BIT] = st.slow;
        rd_val[pmw_pkg::PC_STOP_BIT] = st.stop;
        rd_val[pmw_pkg::PC_SWB_BIT]  = st.switchback_enable;
      end
      pmw_pkg::OFF_WAKE_ENABLE: begin
        rd_val[pmw_pkg::WAKE_N-1:0] = st.wake_en;
      end
      pmw_pkg::OFF_WAKE_PENDING: begin
        rd_val[pmw_pkg::WAKE_N-1:0] = st.pending;
      end
      pmw_pkg::OFF_CONFIG: begin
        rd_val[pmw_pkg::CFG_OSC_OFF_BIT] = st.osc_off;
        rd_val[pmw_pkg::CFG_OSC_RUN_BIT] = osc_pll_en;
      end
      pmw_pkg::OFF_IRQ_STATUS: begin
        rd_val[pmw_pkg::IRQ_N-1:0] = st.irq_st;
      end
      pmw_pkg::OFF_IRQ_MASK: begin
        rd_val[pmw_pkg::IRQ_N-1:0] = st.irq_mask;
      end
      default: begin
        rd_val = '0;
      end
    endcase
    if (acc_en && !pwrite) begin
      next_st.rdata = rd_val;
    end

    if (cfg_load) begin
      next_st.osc_off = cfg_flags[pmw_pkg::CFG_FLAG_OSC_BIT];
    end

    if (wr_en) begin
      case (paddr)
        pmw_pkg::OFF_POWER_CONTROL: begin
          next_st.slow = pwdata[pmw_pkg::PC_SLOW_BIT];
          next_st.switchback_enable  = pwdata[pmw_pkg::PC_SWB_BIT];
          // Stop is only left through a wake or reset, never by writing zero.
          if (pwdata[pmw_pkg::PC_STOP_BIT]) begin
            next_st.stop = 1'b1;
          end
        end
        pmw_pkg::OFF_WAKE_ENABLE: begin
          next_st.wake_en = pwdata[pmw_pkg::WAKE_N-1:0];
        end
        pmw_pkg::OFF_WAKE_PENDING: begin
          next_st.pending = st.pending & ~pwdata[pmw_pkg::WAKE_N-1:0];
        end
        pmw_pkg::OFF_IRQ_STATUS: begin
          next_st.irq_st = st.irq_st & ~pwdata[pmw_pkg::IRQ_N-1:0];
        end
        pmw_pkg::OFF_IRQ_MASK: begin
          next_st.irq_mask = pwdata[pmw_pkg::IRQ_N-1:0];
        end
        default: begin
          next_st.slow = next_st.slow;
        end
      endcase
    end

    // Hardware events come last so that they win over a clearing write.
    next_st.pending = next_st.pending | wake_set;
    if (|wake_set) begin
      next_st.irq_st[pmw_pkg::IRQ_WAKE] = 1'b1;
    end
    if (sb_go || wake_sb) begin
      next_st.slow = 1'b0;
      next_st.irq_st[pmw_pkg::IRQ_SWITCHBACK] = 1'b1;
    end
    if (stop_exit) begin
      next_st.stop     = 1'b0;
      next_st.slow     = 1'b0;
      next_st.vec_addr = pmw_pkg::WAKE_VECTOR;
      next_st.vec_load = 1'b1;
      next_st.irq_st[pmw_pkg::IRQ_STOP_EXIT] = 1'b1;
    end
  end

  // Reset leaves stop and points the CPU at the reset vector.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '{slow: 1'b0, stop: 1'b0, switchback_enable: 1'b0, osc_off: 1'b0, wake_en: '0, pending: '0,
              irq_st: '0, irq_mask: '0, ack: 1'b0, rdata: '0,
              vec_addr: pmw_pkg::RESET_VECTOR, vec_load: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign cif.mode        = st.stop ? pmw_pkg::PMW_STOP
                         : (st.slow ? pmw_pkg::PMW_SLOW : pmw_pkg::PMW_FULL);
  assign sys_clk_en      = cif.sys_clk_en;
  assign osc_pll_en      = !(st.stop && st.osc_off);
  // The stall starts in the cycle the stop write completes, so the
  // instruction after it never issues before the clock is gated.
  assign cpu_stall       = st.stop || stop_wr;
  assign timers_halt     = st.stop;
  assign serial_halt     = st.stop;
  assign wake_interrupt  = |st.pending;
  assign wake_irq_prio   = pmw_pkg::WAKE_PRIO;
  assign cpu_vector_addr = st.vec_addr;
  assign cpu_vector_load = st.vec_load;
  assign irq             = |(st.irq_st & st.irq_mask);
  assign pready          = st.ack;
  assign prdata          = st.rdata;
  assign pslverr         = st.ack && !mapped;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_STOP_ENTER: assert property (
    stop_wr |=> st.stop && cpu_stall && timers_halt && serial_halt)
    else $error("Stop write did not enter stop mode.");

  AST_SLOW_FOLLOWS: assert property (
    (wr_en && paddr == pmw_pkg::OFF_POWER_CONTROL && !sb_go && !(|wake_set))
    |=> st.slow == $past(pwdata[pmw_pkg::PC_SLOW_BIT]))
    else $error("Slow mode bit did not follow the write.");

  AST_SWITCHBACK: assert property (
    sb_go |=> !st.slow ##1 sys_clk_en)
    else $error("Switchback did not return to full speed.");

  AST_STOP_GATED: assert property (
    st.stop |=> !sys_clk_en)
    else $error("Clock ran during stop mode.");

  AST_OSC_OFF_HOLD: assert property (
    (st.stop && st.osc_off && !(|(wake_evt & pmw_pkg::WAKE_OSC_OFF_MASK))) |=> st.stop)
    else $error("Stop left by a source blocked with the oscillator off.");

  AST_CLOCKED_NO_WAKE: assert property (
    (st.stop && sb_evt && !(|wake_set)) |=> st.stop)
    else $error("Clocked source woke the device from stop.");

  AST_WAKE_VECTOR: assert property (
    stop_exit |=> cpu_vector_load && cpu_vector_addr == pmw_pkg::WAKE_VECTOR
                  && wake_interrupt ##1 !cpu_vector_load)
    else $error("Stop exit did not load the wake vector.");

  AST_PENDING: assert property (
    (|wake_set) |=> (st.pending & $past(wake_set)) == $past(wake_set))
    else $error("Wake pending flag lost.");

  AST_OSC_STOP: assert property (
    (stop_wr && st.osc_off && !cfg_load) |=> !osc_pll_en)
    else $error("Oscillator kept running though configured off.");

  AST_APB_ONE_WAIT: assert property (
    acc_en |=> pready ##1 !pready)
    else $error("APB answer not after exactly one wait state.");

  AST_SB_NEEDS_ENABLE: assert property (
    (st.slow && !st.switchback_enable && !st.stop && !(|wake_set)
     && !(wr_en && paddr == pmw_pkg::OFF_POWER_CONTROL)) |=> st.slow)
    else $error("Slow mode left without switchback enable.");

  AST_WAKE_CLOCK: assert property (
    stop_exit |=> !st.stop ##1 sys_clk_en)
    else $error("Stop wake did not restart the system clock.");

  AST_RESET_VECTOR: assert property (
    $fell(rst) |-> cpu_vector_load && !timers_halt
                   && cpu_vector_addr == pmw_pkg::RESET_VECTOR)
    else $error("Reset release did not point the CPU at the reset vector.");
endmodule
`default_nettype wire

// ---- rtl/pmw_wake_edge.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmw_wake_edge #(
  parameter bit RISE = 1'b1
) (
  input  wire logic core_clk, // Main clock.
  input  wire logic rst,      // Asynchronous reset, active high.
  input  wire logic level,    // Watched input.
  output logic      pulse     // One cycle on the chosen edge.
);
  typedef struct packed {
    logic armed;
    logic prev;
    logic pulse;
  } pmw_edge_st_t;

  pmw_edge_st_t st;
  pmw_edge_st_t next_st;

  always_comb begin
    next_st       = st;
    next_st.armed = 1'b1;
    next_st.prev  = level;
    next_st.pulse = st.armed & (RISE ? (level & ~st.prev) : (~level & st.prev));
  end

  // The first cycle after reset only takes in the level, so that a pin
  // already active at reset release does not count as an edge.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= '{armed: 1'b0, prev: ~RISE, pulse: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
endmodule
`default_nettype wire

// ---- test/pmw_src_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pmw_src_model (
  input  wire logic       core_clk, // Main clock.
  input  wire logic [6:0] act,      // Source requests from the bench, enable bit order.
  output logic      [6:0] pin       // Wake source lines toward the block.
);
  // The two serial-side lines idle high, so their request is a falling edge.
  always_ff @(posedge core_clk) begin
    pin <= act ^ 7'h60;
  end
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] PC = pmw_pkg::OFF_POWER_CONTROL;
  localparam logic [7:0] ENA = pmw_pkg::OFF_WAKE_ENABLE;
  localparam logic [7:0] PEND = pmw_pkg::OFF_WAKE_PENDING;
  localparam logic [7:0] STAT = pmw_pkg::OFF_IRQ_STATUS;
  localparam logic [7:0] MASK = pmw_pkg::OFF_IRQ_MASK;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cfg_load = 0, er;
  logic [7:0] paddr = 0, cfg_flags = 0;
  logic [31:0] pwdata = 0, rd, prdata;
  logic [6:0] ev = 0, act = 0, pin;
  logic pready, pslverr, irq, sys_clk_en, osc_pll_en, cpu_stall, timers_halt, serial_halt;
  logic wake_interrupt, cpu_vector_load;
  logic [3:0] wake_irq_prio;
  logic [23:0] cpu_vector_addr;
  int fail_count = 0, checks_done = 0, n, vloads = 0;
  pmw_src_model src (.core_clk, .act, .pin);
  pmw_top dut (.core_clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata,
    .pslverr, .irq, .ext_irq_a(ev[0]), .ext_irq_b(ev[1]), .tx_load_a(ev[2]), .tx_load_b(ev[3]),
    .wdt_reset(ev[4]), .serial_a_rx_pin(~ev[5]), .serial_b_rx_pin(~ev[6]),
    .remote_wake_pin(pin[0]), .magic_packet(pin[1]), .wakeup_frame(pin[2]),
    .phy_link_up(pin[3]), .sec_phy_link_up(pin[4]), .serial_c_rx_pin(pin[5]),
    .ring_indicator_pin(pin[6]), .cfg_load, .cfg_flags, .sys_clk_en, .osc_pll_en, .cpu_stall,
    .timers_halt, .serial_halt, .wake_interrupt, .wake_irq_prio, .cpu_vector_addr,
    .cpu_vector_load);
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // Counts cycles in which the CPU is told to load a vector.
  always @(posedge core_clk) begin
    if (!rst && cpu_vector_load === 1'b1) vloads++;
  end
  task summarize;
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] g, input logic [63:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task w(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  // The request stands until pready is seen high at a rising edge; the answer is
  // taken at that edge and the request let go, and outputs are read once settled.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    #1;
  endtask
  task pulse(input int k);
    @(posedge core_clk);
    ev[k] <= 1;
    @(posedge core_clk);
    ev[k] <= 0;
    w(5);
  endtask
  task fire(input int k);
    @(posedge core_clk);
    act[k] <= 1;
    repeat (3) @(posedge core_clk);
    act[k] <= 0;
    w(5);
  endtask
  task setup;
    apb(1, MASK, 7);
    apb(1, ENA, 32'h0000_007F);
  endtask
  task stop;
    apb(1, PC, 2);
    w(3);
    chk(sys_clk_en, 0);
  endtask
  initial begin
    repeat (19) @(posedge core_clk);
    #1;
    chk({cpu_vector_load, cpu_vector_addr}, 32'h0100_0000);
    @(posedge core_clk);
    rst <= 0;
    apb(0, 8'h18, 0);
    chk({er, rd}, 33'h1_0000_0000);
    setup;
    apb(1, PC, 1);
    n = 0;
    repeat (200) begin
      @(posedge core_clk);
      #1;
      if (sys_clk_en === 1'b1) n++;
    end
    chk(n, 2);
    apb(0, PC, 0);
    chk(rd, 1);
    for (int k = 0; k < 7; k++) begin
      apb(1, PC, 5);
      pulse(k);
      apb(0, PC, 0);
      chk(rd, 4);
    end
    apb(1, PC, 1);
    pulse(0);
    apb(0, PC, 0);
    chk(rd, 1);
    apb(0, STAT, 0);
    chk({irq, rd}, 33'h1_0000_0002);
    apb(1, MASK, 0);
    chk(irq, 0);
    apb(1, MASK, 7);
    apb(1, STAT, 2);
    chk(irq, 0);
    fire(0);
    apb(0, PC, 0);
    chk(rd, 0);
    for (int k = 0; k < 7; k++) begin
      apb(1, PEND, 32'h0000_007F);
      apb(1, STAT, 7);
      chk(wake_interrupt, 0);
      stop;
      chk({timers_halt, serial_halt, cpu_stall}, 3'b111);
      pulse(k);
      chk(sys_clk_en, 0);
      n = vloads;
      fire(k);
      chk(vloads - n, 1);
      chk({sys_clk_en, wake_interrupt, wake_irq_prio}, 6'h3C);
      chk(cpu_vector_addr, 24'h00_005B);
      apb(0, PEND, 0);
      chk(rd, 1 << k);
      apb(0, STAT, 0);
      chk(rd, 5);
    end
    apb(1, PEND, 32'h0000_007F);
    apb(1, ENA, 32'h0000_007E);
    stop;
    fire(0);
    chk(sys_clk_en, 0);
    @(posedge core_clk);
    rst <= 1;
    w(2);
    chk({timers_halt, sys_clk_en, cpu_vector_load, cpu_vector_addr}, 32'h0300_0000);
    @(posedge core_clk);
    rst <= 0;
    setup;
    @(posedge core_clk);
    cfg_flags <= 8'h02;
    cfg_load <= 1;
    @(posedge core_clk);
    cfg_load <= 0;
    apb(0, pmw_pkg::OFF_CONFIG, 0);
    chk(rd, 3);
    apb(1, PC, 1);
    stop;
    chk(osc_pll_en, 0);
    fire(1);
    chk(sys_clk_en, 0);
    fire(6);
    chk({sys_clk_en, osc_pll_en}, 2'b11);
    summarize;
  end
  initial begin
    #300_000;
    fail_count++;
    summarize;
  end
endmodule
`default_nettype wire
